// [dma_port_pkg.sv]
// Shared constants and types for the DMA programming port
package dma_port_pkg;

	// ************************************************************
	// Command bytes decoded in group six
	// ************************************************************
	localparam logic [7:0] CMD_RESET = 8'hC3;
	localparam logic [7:0] CMD_LOAD = 8'hCF;
	localparam logic [7:0] CMD_ENABLE = 8'h87;
	localparam logic [7:0] CMD_DISABLE = 8'h83;
	localparam logic [7:0] CMD_READ_MASK = 8'hBB;
	localparam logic [7:0] CMD_INIT_READ = 8'hA7;
	localparam logic [7:0] CMD_READ_STATUS = 8'hBF;

	// ************************************************************
	// Field positions inside base and associated bytes
	// ************************************************************
	localparam int G0_SRC_A_BIT = 2;   // 1: port A is source
	localparam int G0_PTR_LSB = 3;     // Four pointer bits 6..3
	localparam int TIMING_PTR_BIT = 6; // Groups one and two
	localparam int G3_MASK_BIT = 3;
	localparam int G3_MATCH_BIT = 4;
	localparam int G3_ENABLE_BIT = 6;
	localparam int G4_B_LOW_BIT = 2;
	localparam int G4_INT_BIT = 4;
	localparam int G5_READY_HIGH_BIT = 3;
	localparam int INT_PULSE_BIT = 3;  // Inside interrupt control byte
	localparam int INT_VECTOR_BIT = 4;

	// ************************************************************
	// Readback layout and reset values
	// ************************************************************
	localparam int NUM_READBACK = 7;
	localparam logic [6:0] READ_MASK_RESET = 7'h7F;
	localparam int ST_XFER_BIT = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_INT_BIT = 3;
	localparam int ST_END_BIT = 5;
	localparam logic [7:0] STATUS_BASE = 8'h00;

	// Pin synchroniser: {ready, rd_n, wr_n, io_request_strobe_n, ce_n, data[7:0]}
	localparam int SYNC_WIDTH = 13;
	localparam logic [12:0] SYNC_INIT = 13'h0F00;

	// ************************************************************
	// Write sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_BASE = 3'b000,
		ST_G0 = 3'b001,
		ST_TIMING_A = 3'b010,
		ST_TIMING_B = 3'b011,
		ST_G3 = 3'b100,
		ST_G4 = 3'b101,
		ST_G6_MASK = 3'b110
	} wr_state_e;

endpackage

// [pin_sync.sv]
// Three-stage pin synchroniser with agreement filter, one per bit
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] stable
);

	// ************************************************************
	// Per-bit chain
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			// First stage feeds only the second; the filter looks at 2 and 3
			always_ff @(posedge clock) begin
				if (rst) begin
					s1_reg <= INIT[i];
					s2_reg <= INIT[i];
					s3_reg <= INIT[i];
					stable[i] <= INIT[i];
				end else begin
					s1_reg <= pins[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						stable[i] <= s3_reg;
					end
				end
			end
		end
	endgenerate

endmodule // pin_sync

// [dma_programming_port.sv]
// Programming and readback front end of a single-channel DMA controller
`timescale 1ns/1ns
module dma_programming_port (
	input wire logic clock,
	input wire logic rst,
	input wire logic chip_enable_n,
	input wire logic io_request_strobe_n,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic [7:0] data_in,
	input wire logic ready_pin,
	input wire logic byte_step,
	output logic [7:0] data_out,
	output logic data_oe_n,
	output logic enabled,
	output logic bus_request,
	output logic [7:0] timing_a,
	output logic [7:0] timing_b,
	output logic [7:0] match_mask,
	output logic [7:0] match_value,
	output logic [7:0] int_control,
	output logic [7:0] pulse_control,
	output logic [7:0] int_vector
);

	// ************************************************************
	// Pin capture
	// ************************************************************
	logic [12:0] pins_s;
	logic [7:0] wr_byte;
	logic wr_act;
	logic rd_act;
	logic wr_act_reg;
	logic rd_act_reg;
	logic wr_pulse;
	logic rd_pulse;
	logic ready_act;

	pin_sync #(
		.WIDTH(dma_port_pkg::SYNC_WIDTH),
		.INIT(dma_port_pkg::SYNC_INIT)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.pins({ready_pin, read_n, write_n, io_request_strobe_n,
			chip_enable_n, data_in}),
		.stable(pins_s)
	);

	// Host access decode; the strobes are filtered so a glitch is not a write
	assign wr_byte = pins_s[7:0];
	assign wr_act = !pins_s[8] && !pins_s[9] && !pins_s[10];
	assign rd_act = !pins_s[8] && !pins_s[9] && !pins_s[11];
	assign wr_pulse = wr_act && !wr_act_reg;
	assign rd_pulse = rd_act && !rd_act_reg;

	// Edge memory for the host strobes
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_act_reg <= 1'b0;
			rd_act_reg <= 1'b0;
		end else begin
			wr_act_reg <= wr_act;
			rd_act_reg <= rd_act;
		end
	end

	// ************************************************************
	// Write sequencer
	// ************************************************************
	dma_port_pkg::wr_state_e wr_state_reg;
	logic [3:0] pend_reg;
	logic [3:0] pend_left;
	logic [15:0] start_a_reg;
	logic [7:0] start_b_reg;
	logic [15:0] length_reg;
	logic [6:0] read_mask_reg;
	logic src_a_reg;
	logic ready_high_reg;
	logic base_pulse;
	logic is_g0;
	logic is_g1;
	logic is_g2;
	logic is_g3;
	logic is_g4;
	logic is_g5;
	logic is_g6;

	// Group identification from the base byte
	assign base_pulse = wr_pulse && (wr_state_reg == dma_port_pkg::ST_BASE);
	assign is_g0 = !wr_byte[7] && (wr_byte[1:0] != 2'h0);
	assign is_g1 = !wr_byte[7] && (wr_byte[2:0] == 3'h4);
	assign is_g2 = !wr_byte[7] && (wr_byte[2:0] == 3'h0);
	assign is_g3 = wr_byte[7] && (wr_byte[1:0] == 2'h0);
	assign is_g4 = wr_byte[7] && (wr_byte[1:0] == 2'h1);
	assign is_g5 = wr_byte[7] && !wr_byte[6] && (wr_byte[2:0] == 3'h2);
	assign is_g6 = wr_byte[7] && (wr_byte[1:0] == 2'h3);
	// Lowest pending pointer is served first, fixing the fill order
	assign pend_left = pend_reg & (pend_reg - 4'h1);

	// Base bytes arm pointers, associated bytes land in order
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_state_reg <= dma_port_pkg::ST_BASE;
			pend_reg <= 4'h0;
			start_a_reg <= 16'h0000;
			start_b_reg <= 8'h00;
			length_reg <= 16'h0000;
			read_mask_reg <= dma_port_pkg::READ_MASK_RESET;
			src_a_reg <= 1'b1;
			ready_high_reg <= 1'b0;
			timing_a <= 8'h00;
			timing_b <= 8'h00;
			match_mask <= 8'h00;
			match_value <= 8'h00;
			int_control <= 8'h00;
			pulse_control <= 8'h00;
			int_vector <= 8'h00;
		end else if (wr_pulse) begin
			case (wr_state_reg)
				dma_port_pkg::ST_BASE: begin
					if (is_g0) begin
						src_a_reg <= wr_byte[dma_port_pkg::G0_SRC_A_BIT];
						pend_reg <= wr_byte[6:3];
						if (wr_byte[6:3] != 4'h0) begin
							wr_state_reg <= dma_port_pkg::ST_G0;
						end
					end else if (is_g1 && wr_byte[dma_port_pkg::TIMING_PTR_BIT]) begin
						wr_state_reg <= dma_port_pkg::ST_TIMING_A;
					end else if (is_g2 && wr_byte[dma_port_pkg::TIMING_PTR_BIT]) begin
						wr_state_reg <= dma_port_pkg::ST_TIMING_B;
					end else if (is_g3) begin
						pend_reg <= {2'b00, wr_byte[dma_port_pkg::G3_MATCH_BIT],
							wr_byte[dma_port_pkg::G3_MASK_BIT]};
						if (wr_byte[4:3] != 2'h0) begin
							wr_state_reg <= dma_port_pkg::ST_G3;
						end
					end else if (is_g4) begin
						pend_reg <= {2'b00, wr_byte[dma_port_pkg::G4_INT_BIT],
							wr_byte[dma_port_pkg::G4_B_LOW_BIT]};
						if (wr_byte[dma_port_pkg::G4_INT_BIT] ||
							wr_byte[dma_port_pkg::G4_B_LOW_BIT]) begin
							wr_state_reg <= dma_port_pkg::ST_G4;
						end
					end else if (is_g5) begin
						ready_high_reg <= wr_byte[dma_port_pkg::G5_READY_HIGH_BIT];
					end else if (is_g6 && wr_byte == dma_port_pkg::CMD_READ_MASK) begin
						wr_state_reg <= dma_port_pkg::ST_G6_MASK;
					end
				end
				dma_port_pkg::ST_G0: begin
					// Port A start then block length, each low before high
					if (pend_reg[0]) begin
						start_a_reg[7:0] <= wr_byte;
					end else if (pend_reg[1]) begin
						start_a_reg[15:8] <= wr_byte;
					end else if (pend_reg[2]) begin
						length_reg[7:0] <= wr_byte;
					end else begin
						length_reg[15:8] <= wr_byte;
					end
					pend_reg <= pend_left;
					if (pend_left == 4'h0) begin
						wr_state_reg <= dma_port_pkg::ST_BASE;
					end
				end
				dma_port_pkg::ST_TIMING_A: begin
					timing_a <= wr_byte;
					wr_state_reg <= dma_port_pkg::ST_BASE;
				end
				dma_port_pkg::ST_TIMING_B: begin
					timing_b <= wr_byte;
					wr_state_reg <= dma_port_pkg::ST_BASE;
				end
				dma_port_pkg::ST_G3: begin
					if (pend_reg[0]) begin
						match_mask <= wr_byte;
					end else begin
						match_value <= wr_byte;
					end
					pend_reg <= pend_left;
					if (pend_left == 4'h0) begin
						wr_state_reg <= dma_port_pkg::ST_BASE;
					end
				end
				dma_port_pkg::ST_G4: begin
					// Interrupt control byte may itself point at pulse and vector
					if (pend_reg[0]) begin
						start_b_reg <= wr_byte;
						pend_reg <= pend_left;
						if (pend_left == 4'h0) begin
							wr_state_reg <= dma_port_pkg::ST_BASE;
						end
					end else if (pend_reg[1]) begin
						int_control <= wr_byte;
						pend_reg <= {wr_byte[dma_port_pkg::INT_VECTOR_BIT],
							wr_byte[dma_port_pkg::INT_PULSE_BIT], 2'b00};
						if (wr_byte[4:3] == 2'h0) begin
							wr_state_reg <= dma_port_pkg::ST_BASE;
						end
					end else begin
						if (pend_reg[2]) begin
							pulse_control <= wr_byte;
						end else begin
							int_vector <= wr_byte;
						end
						pend_reg <= pend_left;
						if (pend_left == 4'h0) begin
							wr_state_reg <= dma_port_pkg::ST_BASE;
						end
					end
				end
				dma_port_pkg::ST_G6_MASK: begin
					read_mask_reg <= wr_byte[6:0];
					wr_state_reg <= dma_port_pkg::ST_BASE;
				end
				default: begin
					wr_state_reg <= dma_port_pkg::ST_BASE;
				end
			endcase
		end
	end

	// ************************************************************
	// Enable state
	// ************************************************************
	logic enable_cmd;
	logic enable_next;
	assign enable_cmd = (is_g6 && wr_byte == dma_port_pkg::CMD_ENABLE) ||
		(is_g3 && wr_byte[dma_port_pkg::G3_ENABLE_BIT]);
	// Value that enabled takes at the next edge; the request follows it
	assign enable_next = base_pulse ? enable_cmd : enabled;

	// Every base byte drops to disabled unless it is itself an enable
	always_ff @(posedge clock) begin
		if (rst) begin
			enabled <= 1'b0;
		end else if (base_pulse) begin
			enabled <= enable_cmd;
		end
	end

	// ************************************************************
	// Counters and status flags
	// ************************************************************
	logic [15:0] byte_count_reg;
	logic [15:0] port_a_count_reg;
	logic [15:0] port_b_count_reg;
	logic xfer_flag_reg;
	logic end_flag_reg;
	logic step_ok;
	logic last_step;
	logic load_cmd;
	logic reset_cmd;

	assign ready_act = pins_s[12] == ready_high_reg;
	assign step_ok = byte_step && bus_request;
	assign last_step = step_ok && (byte_count_reg == length_reg);
	assign load_cmd = base_pulse && (wr_byte == dma_port_pkg::CMD_LOAD);
	assign reset_cmd = base_pulse && (wr_byte == dma_port_pkg::CMD_RESET);

	// Clears come first so a step in the same cycle still sets its flags
	always_ff @(posedge clock) begin
		if (rst) begin
			byte_count_reg <= 16'h0000;
			port_a_count_reg <= 16'h0000;
			port_b_count_reg <= 16'h0000;
			xfer_flag_reg <= 1'b0;
			end_flag_reg <= 1'b0;
		end else begin
			if (load_cmd || reset_cmd) begin
				byte_count_reg <= 16'h0000;
				xfer_flag_reg <= 1'b0;
				end_flag_reg <= 1'b0;
			end
			if (load_cmd && src_a_reg) begin
				port_a_count_reg <= start_a_reg;
			end else if (load_cmd) begin
				port_b_count_reg <= {8'h00, start_b_reg};
			end
			if (step_ok) begin
				byte_count_reg <= byte_count_reg + 16'h0001;
				port_a_count_reg <= port_a_count_reg + 16'h0001;
				port_b_count_reg <= port_b_count_reg + 16'h0001;
				xfer_flag_reg <= 1'b1;
			end
			// Count starts at zero, so the byte seen at length is one extra
			if (last_step) begin
				end_flag_reg <= 1'b1;
			end
		end
	end

	// Bus request only while enabled, ready and short of block end
	// Built from the next enable value so it never outlives a disable
	always_ff @(posedge clock) begin
		if (rst) begin
			bus_request <= 1'b0;
		end else begin
			bus_request <= enable_next && ready_act && !end_flag_reg &&
				!last_step;
		end
	end

	// ************************************************************
	// Readback
	// ************************************************************
	logic [2:0] rd_ptr_reg;
	logic [2:0] first_en;
	logic [2:0] next_en;
	logic [7:0] status_byte;
	logic [7:0] rb_value;
	logic rd_cmd;

	// Scan upward from start, wrapping, for the next unmasked register
	function automatic logic [2:0] seek(input logic [2:0] start,
		input logic [6:0] mask);
		int j;
		logic [2:0] hit;
		logic found;
		hit = start;
		found = 1'b0;
		for (int i = 0; i < dma_port_pkg::NUM_READBACK; i++) begin
			j = int'(start) + i;
			if (j >= dma_port_pkg::NUM_READBACK) begin
				j = j - dma_port_pkg::NUM_READBACK;
			end
			if (!found && mask[j]) begin
				hit = 3'(j);
				found = 1'b1;
			end
		end
		return hit;
	endfunction

	assign first_en = seek(3'h0, read_mask_reg);
	assign next_en = seek((rd_ptr_reg == 3'h6) ? 3'h0 : rd_ptr_reg + 3'h1,
		read_mask_reg);
	assign rd_cmd = base_pulse && is_g6 &&
		(wr_byte == dma_port_pkg::CMD_INIT_READ ||
		wr_byte == dma_port_pkg::CMD_READ_STATUS);

	// Active-low flags; no interrupt logic here, so pending never reads true
	always_comb begin
		status_byte = dma_port_pkg::STATUS_BASE;
		status_byte[dma_port_pkg::ST_XFER_BIT] = !xfer_flag_reg;
		status_byte[dma_port_pkg::ST_READY_BIT] = !ready_act;
		status_byte[dma_port_pkg::ST_INT_BIT] = 1'b1;
		status_byte[dma_port_pkg::ST_END_BIT] = !end_flag_reg;
	end

	// Register select in ascending order
	always_comb begin
		case (rd_ptr_reg)
			3'h0: rb_value = status_byte;
			3'h1: rb_value = byte_count_reg[7:0];
			3'h2: rb_value = byte_count_reg[15:8];
			3'h3: rb_value = port_a_count_reg[7:0];
			3'h4: rb_value = port_a_count_reg[15:8];
			3'h5: rb_value = port_b_count_reg[7:0];
			3'h6: rb_value = port_b_count_reg[15:8];
			default: rb_value = 8'h00;
		endcase
	end

	// Pointer restarts on read commands and steps after each host read
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_ptr_reg <= 3'h0;
		end else if (rd_cmd) begin
			rd_ptr_reg <= first_en;
		end else if (rd_pulse) begin
			rd_ptr_reg <= next_en;
		end
	end

	// Data bus drive; enable goes low one cycle after the host read becomes active and rises one cycle after it ends
	always_ff @(posedge clock) begin
		if (rst) begin
			data_out <= 8'h00;
			data_oe_n <= 1'b1;
		end else begin
			data_oe_n <= !rd_act;
			if (rd_pulse) begin
				data_out <= rb_value;
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_reset_disabled: assert property (disable iff (1'b0)
		rst |=> !enabled) else $error("not disabled after reset");
	a_no_bus_off: assert property (!enabled |-> !bus_request)
		else $error("bus request while disabled");
	a_no_move_off: assert property (!enabled ##1 !enabled |->
		$stable(byte_count_reg) || $past(load_cmd || reset_cmd))
		else $error("data moved while disabled");
	a_cmd_disables: assert property (base_pulse && !enable_cmd |=>
		!enabled ##1 !enabled) else $error("command left enabled");
	a_g0_route: assert property (base_pulse && is_g0 &&
		wr_byte[3] |=> wr_state_reg == dma_port_pkg::ST_G0 &&
		pend_reg[0]) else $error("group zero not armed");
	a_a_low_fill: assert property (wr_pulse &&
		wr_state_reg == dma_port_pkg::ST_G0 && pend_reg[0] |=>
		start_a_reg[7:0] == $past(wr_byte)) else $error("A low lost");
	a_read_restart: assert property (rd_cmd |=>
		rd_ptr_reg == $past(first_en)) else $error("pointer not reset");
	a_read_data: assert property (rd_pulse && !rd_cmd |=>
		data_out == $past(rb_value) && rd_ptr_reg == $past(next_en))
		else $error("readback order wrong");
	a_load_source: assert property (load_cmd && src_a_reg && !step_ok |=>
		port_a_count_reg == $past(start_a_reg) &&
		$stable(port_b_count_reg)) else $error("load hit dest");
	a_block_end: assert property (last_step |=> end_flag_reg &&
		!status_byte[dma_port_pkg::ST_END_BIT] ##1 !bus_request)
		else $error("block end missed");

	c_enable: cover property (base_pulse && enable_cmd);
	c_block_end: cover property (last_step);
	c_load: cover property (load_cmd);
	c_read: cover property (rd_pulse ##[1:20] rd_pulse);

endmodule // dma_programming_port

// [host_model.sv]
// Host processor model: port writes and readback reads
`timescale 1ns/1ns
module host_model (
	input wire logic clock,
	output logic chip_enable_n,
	output logic io_request_strobe_n,
	output logic write_n,
	output logic read_n,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	// Pins idle from time zero so the reset flush sees them high
	initial begin
		chip_enable_n = 1'b1;
		io_request_strobe_n = 1'b1;
		write_n = 1'b1;
		read_n = 1'b1;
		data_in = 8'h00;
	end

	// One write; held well past the pin filter, then a long high gap
	task automatic wr(input logic [7:0] b);
		@(posedge clock);
		#1;
		data_in = b;
		{chip_enable_n, io_request_strobe_n, write_n} = 3'b000;
		repeat (8) @(posedge clock);
		#1;
		{chip_enable_n, io_request_strobe_n, write_n} = 3'b111;
		data_in = ~b; // Released bus never repeats the byte just sent
		repeat (5) @(posedge clock);
		#1;
	endtask

	// One read; ok stays low if the port never answers or releases
	task automatic rd(output logic [7:0] b, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge clock);
		#1;
		{chip_enable_n, io_request_strobe_n, read_n} = 3'b000;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clock);
			#1;
			ok = (data_oe_n === 1'b0);
		end
		b = data_out;
		{chip_enable_n, io_request_strobe_n, read_n} = 3'b111;
		for (n = 0; n < 20 && data_oe_n !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		if (data_oe_n !== 1'b1)
			ok = 1'b0;
		repeat (4) @(posedge clock);
		#1;
	endtask
endmodule // host_model

// [tb.sv]
// Self-checking testbench of the DMA programming port
`timescale 1ns/1ns
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end

module tb;
	logic clock, rst, ready_pin, byte_step, data_oe_n, enabled, bus_request;
	logic chip_enable_n, io_request_strobe_n, write_n, read_n, ok;
	logic [7:0] data_in, data_out, timing_a, timing_b, match_mask, match_value;
	logic [7:0] int_control, pulse_control, int_vector, seed, got;
	logic [7:0] exp_rb [7];
	logic [7:0] cmds [5] = '{8'h83, 8'h14, 8'h28, 8'h05, 8'hA7};
	logic [6:0] mask;
	logic [15:0] len, moved;
	int miscompares, check_count, k;

	// ************************************************************
	// Clock, host and design
	// ************************************************************
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	host_model host (.clock(clock), .chip_enable_n(chip_enable_n),
		.io_request_strobe_n(io_request_strobe_n), .write_n(write_n),
		.read_n(read_n), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n));

	dma_programming_port uut (.clock(clock), .rst(rst),
		.chip_enable_n(chip_enable_n),
		.io_request_strobe_n(io_request_strobe_n), .write_n(write_n),
		.read_n(read_n), .data_in(data_in), .ready_pin(ready_pin),
		.byte_step(byte_step), .data_out(data_out), .data_oe_n(data_oe_n),
		.enabled(enabled), .bus_request(bus_request), .timing_a(timing_a),
		.timing_b(timing_b), .match_mask(match_mask),
		.match_value(match_value), .int_control(int_control),
		.pulse_control(pulse_control), .int_vector(int_vector));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic end_sim;
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	// First register at or after from that the mask lets through
	function automatic int next_idx(input int from, input logic [6:0] m);
		int j;
		for (j = 0; j < 7; j++) begin
			if (m[(from + j) % 7])
				return (from + j) % 7;
		end
		return from % 7;
	endfunction

	task automatic ws(input logic [7:0] q[$]);
		foreach (q[j])
			host.wr(q[j]);
	endtask

	task automatic set_rb(input logic [7:0] st, input logic [15:0] c, a, b);
		exp_rb = '{st, c[7:0], c[15:8], a[7:0], a[15:8], b[7:0], b[15:8]};
	endtask

	// Reads n bytes, expecting ascending masked order with wrap
	task automatic read_seq(input int n);
		int idx;
		idx = next_idx(0, mask);
		repeat (n) begin
			host.rd(got, ok);
			if (!ok) begin
				miscompares++;
				end_sim();
			end
			`CHK(got, exp_rb[idx])
			idx = next_idx(idx + 1, mask);
		end
	endtask

	task automatic wait_bus(input logic lvl);
		int j;
		for (j = 0; j < 20 && bus_request !== lvl; j++) begin
			@(posedge clock);
			#1;
		end
		if (bus_request !== lvl) begin
			miscompares++;
			end_sim();
		end
	endtask

	// Hang guard: a stuck run still reaches the verdict
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		end_sim();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		ready_pin = 1'b1;
		byte_step = 1'b0;
		seed = 8'h4F;
		mask = 7'h7F;
		miscompares = 0;
		check_count = 0;
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		`CHK({enabled, bus_request, data_oe_n}, 3'b001)
		`CHK({timing_a, timing_b, match_mask, match_value}, 32'h0000_0000)
		`CHK({int_control, pulse_control, int_vector}, 24'h00_0000)
		// Timing bytes of both ports, then mask and match
		seed = lfsr(seed);
		ws('{8'h54, seed, 8'h50, ~seed, 8'h98, 8'h3C, 8'hA5});
		`CHK({timing_a, timing_b}, {seed, ~seed})
		`CHK({match_mask, match_value}, 16'h3CA5)
		// Port B as temporary source; short random block length
		seed = lfsr(seed);
		len = {13'h0000, seed[2:0]};
		ws('{8'h79, 8'h50, 8'h10, len[7:0], len[15:8]});
		ws('{8'h95, 8'h05, 8'h18, 8'h77, 8'h99, 8'hCF});
		`CHK({int_control, pulse_control, int_vector}, 24'h18_7799)
		ws('{8'hA7});
		set_rb(8'h2B, 16'h0000, 16'h0000, 16'h0005);
		read_seq(7);
		ws('{8'h05, 8'hCF, 8'hBF});
		set_rb(8'h2B, 16'h0000, 16'h1050, 16'h0005);
		read_seq(14);
		// Random read masks; a read command restarts the pass
		for (k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			mask = (seed[6:0] == 7'h00) ? 7'h41 : seed[6:0];
			ws('{8'hBB, {1'b0, mask}, 8'hA7});
			read_seq(2 * $countones(mask));
			ws('{8'hBF});
			read_seq($countones(mask));
		end
		mask = 7'h7F;
		ws('{8'hBB, 8'h7F});
		// Each of five non-enable base bytes drops the enable
		for (k = 0; k < 5; k++) begin
			ws('{8'h87});
			`CHK(enabled, 1'b1)
			ws('{cmds[k]});
			`CHK(enabled, 1'b0)
		end
		// Peripheral ready while disabled must not raise a request
		ready_pin = 1'b0;
		repeat (10) @(posedge clock);
		#1;
		`CHK(bus_request, 1'b0)
		ws('{8'h87});
		wait_bus(1'b1);
		// Length plus one steps; request holds until the last
		for (moved = 0; moved <= len; moved++) begin
			`CHK(bus_request, 1'b1)
			byte_step = 1'b1;
			@(posedge clock);
			#1;
			byte_step = 1'b0;
			@(posedge clock);
			#1;
		end
		`CHK(bus_request, 1'b0)
		ws('{8'hA7});
		set_rb(8'h08, moved, 16'h1050 + moved, 16'h0005 + moved);
		read_seq(7);
		// Reset command clears count and flags; address counters keep
		ws('{8'hC3, 8'hA7});
		set_rb(8'h29, 16'h0000, 16'h1050 + moved, 16'h0005 + moved);
		read_seq(7);
		// Ready turned active high; a group three base byte enables
		ws('{8'h8A, 8'hA7, 8'hC0});
		`CHK({enabled, bus_request}, 2'b10)
		set_rb(8'h2B, 16'h0000, 16'h1050 + moved, 16'h0005 + moved);
		read_seq(1);
		end_sim();
	end
endmodule // tb
